// [core/ds1_port_pkg.sv]
// Notes on behaviour
// - Monitor mode keeps the line transmitter off and only observes the receive signal.
// - Bridged mode keeps the transmitter off and watches the line unterminated.
// - Terminate mode drives the transmitter and uses a chosen transmit timing source.
// - Recovered line timing clocks transmit from the receive clock; it is the default.
// - Internal timing derives a 1.544 MHz bit rate within 10 ppm.
// - Emulation mode detects CSU, NIU-4 and NIU-5 loop-ups and signals the type.
// - While an emulated loopback is active, received data is sent back out.
// - Reset gives monitor, recovered timing, ESF, B8ZS and bit error test off.
// - Transmit framing is ESF, SF, SLC or unframed.
// - Auto configuration follows detected framing and coding of the received signal.
// - Auto coding becomes B8ZS only from code words, never from dense patterns.
// - Loss of signal, out of frame, AIS and yellow alarms each show their active state and latch history once they end.
// - Clear resets every alarm history, event indicator and counter at once.
// - Line coding is B8ZS by default, or AMI.
// - B8ZS-detected is up while code words arrive and drops 1 ms after the last one.
// - Excessive jitter is up while jitter exceeds the 128-bit attenuator depth.
// - Robbed signalling bits A, B, C, D are kept for all 24 channels.
// - Transmit and receive bytes of one selected channel are readable.
// - Fractional mode bit error tests any chosen set of channels.
// - A command of the armed family is always preceded by the arming command.
package ds1_port_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_STATUS    = 4'h1;
    localparam logic [3:0] REG_CLEAR     = 4'h2;
    localparam logic [3:0] REG_CHAN_SEL  = 4'h3;
    localparam logic [3:0] REG_CHAN_DATA = 4'h4;
    localparam logic [3:0] REG_SIG       = 4'h5;
    localparam logic [3:0] REG_FRAC_MASK = 4'h6;
    localparam logic [3:0] REG_HDSL_CMD  = 4'h7;
    localparam logic [3:0] REG_EVENTS    = 4'h8;
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_TIMING    = 3;
    localparam int CTRL_FRAME_LSB = 4;
    localparam int CTRL_AUTO      = 6;
    localparam int CTRL_CODE      = 7;
    localparam int CTRL_BERT      = 8;
    localparam int HDSL_ARMED_FAM = 8;
    localparam logic [2:0] MODE_MONITOR = 3'h0;
    localparam logic [2:0] MODE_BRIDGED = 3'h1;
    localparam logic [2:0] MODE_TERM    = 3'h2;
    localparam logic [2:0] MODE_EMUL    = 3'h3;
    localparam logic [2:0] MODE_FRAC    = 3'h4;
    localparam logic [1:0] FRAME_ESF    = 2'h0;
    localparam logic [1:0] FRAME_SF     = 2'h1;
    localparam logic [1:0] FRAME_SLC    = 2'h2;
    localparam logic [1:0] FRAME_UNFR   = 2'h3;
    localparam logic [1:0] LOOP_CSU     = 2'h1;
    localparam logic [1:0] LOOP_NIU4    = 2'h2;
    localparam logic [1:0] LOOP_NIU5    = 2'h3;
    localparam logic [7:0] ARM_CODE     = 8'h01;
    localparam logic [23:0] FRAC_RESET  = 24'h000000;
    localparam int CHANNELS = 24;
    localparam int JITTER_LIMIT_BITS = 128;
    localparam int EVT_W = 16;
    localparam longint CLK_HZ = 10_000_000;
    localparam longint OSC_HZ = 1_544_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int NCO_W = 24;
    localparam logic [23:0] NCO_STEP = 24'((OSC_HZ * (64'd1 << NCO_W)) / CLK_HZ);
    localparam int B8ZS_HOLD_NS = 1_000_000;
    localparam int B8ZS_HOLD_CYC = B8ZS_HOLD_NS / CLK_PERIOD_NS;
    typedef enum logic [4:0] {
        M_MON  = 5'b00001,
        M_BRG  = 5'b00010,
        M_TERM = 5'b00100,
        M_EMU  = 5'b01000,
        M_FRAC = 5'b10000
    } mode_t;
    typedef enum logic [4:0] {
        H_IDLE     = 5'b00001,
        H_ARM      = 5'b00010,
        H_ARM_WAIT = 5'b00100,
        H_CMD      = 5'b01000,
        H_CMD_WAIT = 5'b10000
    } hdsl_t;
endpackage

// [core/ds1_port_ctrl.sv]
`timescale 1ns/10ps
module ds1_port_ctrl #(
    parameter int B8ZS_HOLD = ds1_port_pkg::B8ZS_HOLD_CYC
) (
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    input  wire logic [ds1_port_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [ds1_port_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [ds1_port_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic                              rx_bit_en,
    input  wire logic                              rx_data,
    input  wire logic                              los,
    input  wire logic                              oof,
    input  wire logic                              ais,
    input  wire logic                              yel,
    input  wire logic                              frame_lock,
    input  wire logic [1:0]                        det_framing,
    input  wire logic                              bpv_pulse,
    input  wire logic                              crc_pulse,
    input  wire logic                              fbit_pulse,
    input  wire logic                              b8zs_word,
    input  wire logic                              zero_run,
    input  wire logic [7:0]                        jitter_depth,
    input  wire logic                              loop_up_csu,
    input  wire logic                              loop_up_niu4,
    input  wire logic                              loop_up_niu5,
    input  wire logic                              loop_down,
    input  wire logic                              tx_pattern,
    input  wire logic [4:0]                        tx_chan_idx,
    input  wire logic [7:0]                        tx_chan_byte,
    input  wire logic                              tx_chan_valid,
    input  wire logic [4:0]                        rx_chan_idx,
    input  wire logic [7:0]                        rx_chan_byte,
    input  wire logic                              rx_chan_valid,
    input  wire logic [3:0]                        rx_sig_abcd,
    input  wire logic                              rx_sig_valid,
    input  wire logic                              hdsl_done,
    output logic                                   tx_en,
    output logic                                   rx_hiz,
    output logic                                   tx_bit_en,
    output logic                                   tx_data,
    output logic                                   tx_timing_internal,
    output logic      [1:0]                        frame_sel,
    output logic                                   code_ami,
    output logic                                   bert_chan_en,
    output logic                                   loop_beep,
    output logic                                   hdsl_send,
    output logic      [7:0]                        hdsl_code
);
    import ds1_port_pkg::*;

    // Illegal mode codes leave the current mode in place.
    function automatic mode_t mode_decode(input logic [2:0] code, input mode_t cur);
        mode_t m;
        m = cur;
        unique case (code)
            MODE_MONITOR: m = M_MON;
            MODE_BRIDGED: m = M_BRG;
            MODE_TERM:    m = M_TERM;
            MODE_EMUL:    m = M_EMU;
            MODE_FRAC:    m = M_FRAC;
            default:      m = cur;
        endcase
        return m;
    endfunction

    function automatic logic [2:0] mode_code(input mode_t m);
        logic [2:0] c;
        c = MODE_MONITOR;
        unique case (m)
            M_MON:  c = MODE_MONITOR;
            M_BRG:  c = MODE_BRIDGED;
            M_TERM: c = MODE_TERM;
            M_EMU:  c = MODE_EMUL;
            M_FRAC: c = MODE_FRAC;
        endcase
        return c;
    endfunction

    function automatic logic chan_ok(input logic [4:0] idx);
        return idx < 5'(CHANNELS);
    endfunction

    mode_t             mode;
    hdsl_t             hst;
    logic              timing_internal;
    logic [1:0]        frame_cfg;
    logic              auto_cfg;
    logic              code_cfg_ami;
    logic              bert_en;
    logic [NCO_W-1:0]  nco_acc;
    logic              loop_active;
    logic [1:0]        loop_type;
    logic              auto_ami;
    logic [3:0]        prev_act;
    logic [3:0]        hist;
    logic [EVT_W-1:0]  evt_cnt;
    logic [15:0]       b8zs_cnt;
    logic              b8zs_seen;
    logic              jitter_alarm;
    logic              no_errors;
    logic [4:0]        chan_sel;
    logic [7:0]        tx_byte_sel;
    logic [7:0]        rx_byte_sel;
    logic [3:0]        sig_mem [CHANNELS];
    logic [23:0]       frac_mask;
    logic [7:0]        hdsl_cmd;
    logic              hdsl_fam;

    wire wr_ctrl  = reg_wr && reg_addr == REG_CTRL;
    wire clr      = reg_wr && reg_addr == REG_CLEAR && reg_wdata[0];
    wire wr_chan  = reg_wr && reg_addr == REG_CHAN_SEL;
    wire wr_frac  = reg_wr && reg_addr == REG_FRAC_MASK;
    wire wr_hdsl  = reg_wr && reg_addr == REG_HDSL_CMD;
    wire [NCO_W:0] nco_sum = {1'b0, nco_acc} + {1'b0, NCO_STEP};
    wire nco_tick = nco_sum[NCO_W];
    wire term_like = mode == M_TERM || mode == M_EMU || mode == M_FRAC;
    wire [3:0] act = {yel, ais, oof, los};
    wire [3:0] ended = prev_act & ~act;
    wire evt_any = bpv_pulse | crc_pulse | fbit_pulse;
    wire loop_up = loop_up_csu | loop_up_niu4 | loop_up_niu5;
    wire [1:0] next_loop_type = loop_up_niu5 ? LOOP_NIU5 :
                                loop_up_niu4 ? LOOP_NIU4 : LOOP_CSU;
    wire next_loop_active = mode == M_EMU && !loop_down && (loop_active || loop_up);
    wire [1:0] frame_eff = auto_cfg ? det_framing : frame_cfg;
    wire code_eff_ami = auto_cfg ? auto_ami : code_cfg_ami;
    wire bit_tick = timing_internal ? nco_tick : rx_bit_en;
    wire next_no_errors = frame_lock && act == 4'h0 && hist == 4'h0
                          && evt_cnt == '0 && !jitter_alarm;
    wire [31:0] status_word = {13'h0000, hst != H_IDLE, frame_eff, code_eff_ami,
                               frame_lock, loop_type, loop_active, no_errors,
                               jitter_alarm, b8zs_seen, hist, act};
    wire [31:0] ctrl_word = {23'h000000, bert_en, code_cfg_ami, auto_cfg, frame_cfg,
                             timing_internal, mode_code(mode)};
    wire [31:0] rd_word =
        reg_addr == REG_CTRL      ? ctrl_word :
        reg_addr == REG_STATUS    ? status_word :
        reg_addr == REG_CHAN_SEL  ? {27'h0000000, chan_sel} :
        reg_addr == REG_CHAN_DATA ? {16'h0000, tx_byte_sel, rx_byte_sel} :
        reg_addr == REG_SIG       ? {28'h0000000, chan_ok(chan_sel) ?
                                     sig_mem[chan_sel] : 4'h0} :
        reg_addr == REG_FRAC_MASK ? {8'h00, frac_mask} :
        reg_addr == REG_HDSL_CMD  ? {23'h000000, hdsl_fam, hdsl_cmd} :
        reg_addr == REG_EVENTS    ? {16'h0000, evt_cnt} : 32'h00000000;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode            <= M_MON;
            timing_internal <= 1'b0;
            frame_cfg       <= FRAME_ESF;
            auto_cfg        <= 1'b0;
            code_cfg_ami    <= 1'b0;
            bert_en         <= 1'b0;
        end else if (wr_ctrl) begin
            mode            <= mode_decode(reg_wdata[CTRL_MODE_LSB +: 3], mode);
            timing_internal <= reg_wdata[CTRL_TIMING];
            frame_cfg       <= reg_wdata[CTRL_FRAME_LSB +: 2];
            auto_cfg        <= reg_wdata[CTRL_AUTO];
            code_cfg_ami    <= reg_wdata[CTRL_CODE];
            bert_en         <= reg_wdata[CTRL_BERT];
        end
    end

    // Phase accumulator overflows at 1.544 MHz on average, well inside 10 ppm.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            nco_acc <= '0;
        end else begin
            nco_acc <= nco_sum[NCO_W-1:0];
        end
    end

    // A looped port always retimes from the line, whatever timing is chosen.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_en              <= 1'b0;
            rx_hiz             <= 1'b0;
            tx_bit_en          <= 1'b0;
            tx_data            <= 1'b0;
            tx_timing_internal <= 1'b0;
        end else begin
            tx_en              <= term_like;
            rx_hiz             <= mode == M_BRG;
            tx_bit_en          <= term_like && (loop_active ? rx_bit_en : bit_tick);
            tx_data            <= loop_active ? rx_data : tx_pattern;
            tx_timing_internal <= timing_internal && !loop_active;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            loop_active <= 1'b0;
            loop_type   <= 2'h0;
            loop_beep   <= 1'b0;
        end else begin
            loop_active <= next_loop_active;
            loop_beep   <= mode == M_EMU && !loop_down && loop_up;
            if (mode == M_EMU && loop_up && !loop_down) begin
                loop_type <= next_loop_type;
            end else if (!next_loop_active) begin
                loop_type <= 2'h0;
            end
        end
    end

    // A code word wins over a plain zero run; dense data changes nothing.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            auto_ami  <= 1'b0;
            frame_sel <= FRAME_ESF;
            code_ami  <= 1'b0;
        end else begin
            if (b8zs_word) begin
                auto_ami <= 1'b0;
            end else if (zero_run) begin
                auto_ami <= 1'b1;
            end
            frame_sel <= frame_eff;
            code_ami  <= code_eff_ami;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prev_act     <= 4'h0;
            hist         <= 4'h0;
            evt_cnt      <= '0;
            no_errors    <= 1'b0;
            jitter_alarm <= 1'b0;
        end else begin
            prev_act     <= act;
            hist         <= (hist & {4{~clr}}) | ended;
            if (clr) begin
                evt_cnt <= evt_any ? EVT_W'(1) : '0;
            end else if (evt_any && evt_cnt != '1) begin
                evt_cnt <= evt_cnt + EVT_W'(1);
            end
            no_errors    <= next_no_errors;
            jitter_alarm <= jitter_depth > 8'(JITTER_LIMIT_BITS);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            b8zs_cnt  <= 16'h0000;
            b8zs_seen <= 1'b0;
        end else if (b8zs_word) begin
            b8zs_cnt  <= 16'(B8ZS_HOLD);
            b8zs_seen <= 1'b1;
        end else if (clr) begin
            b8zs_cnt  <= 16'h0000;
            b8zs_seen <= 1'b0;
        end else begin
            if (b8zs_cnt != 16'h0000) begin
                b8zs_cnt <= b8zs_cnt - 16'h0001;
            end
            b8zs_seen <= b8zs_cnt > 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            chan_sel    <= 5'h00;
            tx_byte_sel <= 8'h00;
            rx_byte_sel <= 8'h00;
            frac_mask   <= FRAC_RESET;
        end else begin
            if (wr_chan) begin
                chan_sel <= reg_wdata[4:0];
            end
            if (wr_frac) begin
                frac_mask <= reg_wdata[23:0];
            end
            if (tx_chan_valid && tx_chan_idx == chan_sel) begin
                tx_byte_sel <= tx_chan_byte;
            end
            if (rx_chan_valid && rx_chan_idx == chan_sel) begin
                rx_byte_sel <= rx_chan_byte;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rx_sig_valid && chan_ok(rx_chan_idx)) begin
            sig_mem[rx_chan_idx] <= rx_sig_abcd;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bert_chan_en <= 1'b0;
        end else begin
            bert_chan_en <= bert_en && chan_ok(tx_chan_idx)
                            && (mode != M_FRAC || frac_mask[tx_chan_idx]);
        end
    end

    // Commands written while a command is in flight are dropped.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hst       <= H_IDLE;
            hdsl_cmd  <= 8'h00;
            hdsl_fam  <= 1'b0;
            hdsl_send <= 1'b0;
            hdsl_code <= 8'h00;
        end else begin
            hdsl_send <= 1'b0;
            unique case (hst)
                H_IDLE: if (wr_hdsl) begin
                    hdsl_cmd  <= reg_wdata[7:0];
                    hdsl_fam  <= reg_wdata[HDSL_ARMED_FAM];
                    hdsl_send <= 1'b1;
                    hdsl_code <= reg_wdata[HDSL_ARMED_FAM] ? ARM_CODE : reg_wdata[7:0];
                    hst       <= reg_wdata[HDSL_ARMED_FAM] ? H_ARM_WAIT : H_CMD_WAIT;
                end
                H_ARM: hst <= H_ARM_WAIT;
                H_ARM_WAIT: if (hdsl_done) begin
                    hst <= H_CMD;
                end
                H_CMD: begin
                    hdsl_send <= 1'b1;
                    hdsl_code <= hdsl_cmd;
                    hst       <= H_CMD_WAIT;
                end
                H_CMD_WAIT: if (hdsl_done) begin
                    hst <= H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= reg_rd ? rd_word : 32'h00000000;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_MON_TX_OFF: assert property (mode == M_MON |=> !tx_en && !tx_bit_en)
        else $error("transmitter active in monitor mode");
    AST_BRIDGE_HIZ: assert property (mode == M_BRG |=> rx_hiz && !tx_en)
        else $error("bridged mode not high impedance or transmitting");
    AST_TERM_TX: assert property (mode == M_TERM |=> tx_en && !rx_hiz)
        else $error("terminate mode without transmitter");
    AST_REC_TIMING: assert property (term_like && !timing_internal |=>
                                     tx_bit_en == $past(rx_bit_en))
        else $error("recovered timing not followed");
    // Only ticks launched by the accumulator count; a timing change ends the window.
    AST_NCO_SPACING: assert property (mode == M_TERM && timing_internal && tx_bit_en
                                      && $past(timing_internal) && !$past(loop_active)
                                      |=> (!tx_bit_en || !$past(timing_internal)) [*5])
        else $error("internal bit rate too fast");
    AST_RESET_DEF: assert property (disable iff (1'b0) rst |=> mode == M_MON
        && !timing_internal && frame_cfg == FRAME_ESF && !code_cfg_ami && !bert_en)
        else $error("reset defaults wrong");
    AST_LOOP_DETECT: assert property (mode == M_EMU && loop_up_niu5 && !loop_down |=>
                                      loop_active && loop_beep && loop_type == LOOP_NIU5)
        else $error("loopback code not detected");
    AST_LOOP_DATA: assert property (loop_active |=> tx_data == $past(rx_data))
        else $error("loopback data not returned");
    AST_AUTO_B8ZS: assert property (auto_cfg && !b8zs_word && !zero_run ##1 auto_cfg
                                    |=> code_ami == $past(code_ami))
        else $error("coding changed without code word or zero run");
    AST_HISTORY: assert property (prev_act[0] && !los |=> hist[0])
        else $error("ended loss of signal not latched");
    AST_CLEAR: assert property (clr && !evt_any && act == 4'h0 && prev_act == 4'h0 |=>
                                evt_cnt == '0 && hist == 4'h0)
        else $error("clear left indicators set");
    AST_NO_ERRORS: assert property (no_errors |-> $past(frame_lock) && $past(act) == 4'h0)
        else $error("no-errors shown while not clean");
    AST_B8ZS_SEEN: assert property (b8zs_word ##1 !clr |-> b8zs_seen ##1 b8zs_seen)
        else $error("code word not flagged");
    AST_JITTER: assert property (jitter_depth > 8'd128 |=> jitter_alarm)
        else $error("excess jitter not flagged");
    AST_ARM_FIRST: assert property (hst == H_IDLE && wr_hdsl && reg_wdata[HDSL_ARMED_FAM]
                                    |=> hdsl_send && hdsl_code == ARM_CODE)
        else $error("armed command sent without arming");

    CVR_LOOP_UP: cover property (mode == M_EMU ##1 loop_beep ##1 loop_active);
    CVR_CLEAR: cover property (hist != 4'h0 ##1 clr ##1 hist == 4'h0);
    CVR_ARM_SEQ: cover property (hst == H_ARM_WAIT ##[1:20] hst == H_CMD);
    CVR_CLEAN: cover property (!no_errors ##1 no_errors);
endmodule

// [sim/t1_line_model.sv]
`timescale 1ns/10ps
module t1_line_model (
    input  wire logic core_clk,
    input  wire logic rst,
    output logic      rx_bit_en,
    output logic      rx_data
);
    logic [2:0] div;
    logic [6:0] lfsr;
    // Between bits the data line toggles, so a stale bit never looks valid.
    always_ff @(posedge core_clk) begin
        div <= (rst || div == 3'h6) ? 3'h0 : div + 3'h1;
        lfsr <= rst ? 7'h5a : {lfsr[5:0], lfsr[6] ^ lfsr[5]};
        rx_bit_en <= !rst && div == 3'h6;
        rx_data <= rst ? 1'h0 : (div == 3'h6 ? lfsr[0] : ~rx_data);
    end
endmodule

// [sim/ds1_test_port_control_bench.sv]
`timescale 1ns/10ps
module ds1_test_port_control_bench;
    import ds1_port_pkg::*;
    logic        core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_q = 0, en_q, d_q;
    logic [3:0]  reg_addr = 0, alm = 0, rx_sig_abcd = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic [1:0]  det_framing = 0, frame_sel;
    logic [2:0]  lu = 0, ev = 0;
    logic [7:0]  jitter_depth = 0, tx_chan_byte = 0, rx_chan_byte = 0, hdsl_code;
    logic [4:0]  tx_chan_idx = 0, rx_chan_idx = 0;
    logic        loop_down = 0, zero_run = 0, b8zs_word = 0, hdsl_done = 0, tx_pattern = 0;
    logic        frame_lock = 0, tx_chan_valid = 0, rx_chan_valid = 0, rx_sig_valid = 0;
    logic        rx_bit_en, rx_data, tx_en, rx_hiz, tx_bit_en, tx_data, tx_timing_internal;
    logic        code_ami, bert_chan_en, loop_beep, hdsl_send;
    logic [63:0] q[$];
    logic [63:0] nt;
    int          err_count = 0, cmp_count = 0, seed = 69682, n;

    ds1_port_ctrl #(.B8ZS_HOLD(20)) DUT (
        .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_bit_en,
        .rx_data, .los(alm[0]), .oof(alm[1]), .ais(alm[2]), .yel(alm[3]), .frame_lock,
        .det_framing, .bpv_pulse(ev[0]), .crc_pulse(ev[1]), .fbit_pulse(ev[2]), .b8zs_word,
        .zero_run, .jitter_depth, .loop_up_csu(lu[0]), .loop_up_niu4(lu[1]),
        .loop_up_niu5(lu[2]), .loop_down, .tx_pattern, .tx_chan_idx, .tx_chan_byte,
        .tx_chan_valid, .rx_chan_idx, .rx_chan_byte, .rx_chan_valid, .rx_sig_abcd,
        .rx_sig_valid, .hdsl_done, .tx_en, .rx_hiz, .tx_bit_en, .tx_data, .tx_timing_internal,
        .frame_sel, .code_ami, .bert_chan_en, .loop_beep, .hdsl_send, .hdsl_code);
    t1_line_model LINE (.core_clk, .rst, .rx_bit_en, .rx_data);

    initial begin
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        {tx_pattern, tx_chan_valid, rx_chan_valid, rx_sig_valid, frame_lock, ev} <= 8'($random(seed));
        {tx_chan_byte, rx_chan_byte, rx_sig_abcd} <= 20'($random(seed));
        tx_chan_idx <= 5'($unsigned($random(seed)) % 24);
        rx_chan_idx <= 5'($unsigned($random(seed)) % 24);
        en_q <= rx_bit_en;
        d_q <= rx_data;
        rd_q <= reg_rd;
    end
    always @(negedge core_clk) begin
        if (rd_q) begin
            nt = q.pop_front();
            chk(reg_rdata & nt[63:32], nt[31:0]);
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk) reg_wr <= 1'h0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        q.push_back({m, e});
        @(posedge core_clk) reg_rd <= 1'h0;
    endtask
    task finish_test;
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        err_count++;
        finish_test;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'h0;
        rd(REG_CTRL, 32'hffffffff, 32'h0);
        rd(4'hf, 32'hffffffff, 32'h0);
        @(negedge core_clk);
        chk({tx_en, rx_hiz, tx_timing_internal, frame_sel, code_ami, bert_chan_en}, 7'h0);
        for (n = 0; n < 5; n++) begin
            wr(REG_CTRL, 32'(n) | (32'(n % 4) << CTRL_FRAME_LSB));
            repeat (2) @(negedge core_clk);
            chk({tx_en, rx_hiz, frame_sel}, {n > 1, n == 1, 2'(n % 4)});
        end
        wr(REG_CTRL, 32'(MODE_TERM));
        repeat (30) @(negedge core_clk) chk({tx_timing_internal, tx_bit_en}, {1'h0, en_q});
        wr(REG_CTRL, 32'(MODE_TERM) | 32'h8);
        @(negedge core_clk) n = 0;
        repeat (1000) @(negedge core_clk) n += tx_bit_en;
        chk({tx_timing_internal, n > 153 && n < 156}, 2'h3);
        for (n = 0; n < 3; n++) begin
            wr(REG_CTRL, 32'(MODE_TERM));
            wr(REG_CTRL, 32'(MODE_EMUL));
            @(posedge core_clk) lu <= 3'(1 << n);
            @(posedge core_clk) lu <= 3'h0;
            @(negedge core_clk) chk(loop_beep, 1'h1);
            rd(REG_STATUS, 32'h3800, 32'h800 | (32'(n + 1) << 12));
            repeat (30) @(negedge core_clk) if (en_q === 1'h1) chk(tx_data, d_q);
            @(posedge core_clk) loop_down <= 1'h1;
            @(posedge core_clk) loop_down <= 1'h0;
            rd(REG_STATUS, 32'h800, 32'h0);
        end
        wr(REG_CTRL, 32'h0);
        for (n = 0; n < 4; n++) begin
            @(posedge core_clk) alm <= 4'(1 << n);
            repeat (3) @(posedge core_clk);
            rd(REG_STATUS, 32'hff, 32'(1 << n));
            alm <= 4'h0;
            repeat (2) @(posedge core_clk);
            rd(REG_STATUS, 32'hff, 32'(16 << n));
            wr(REG_CLEAR, 32'h1);
            rd(REG_STATUS, 32'hff, 32'h0);
        end
        jitter_depth <= 8'h81;
        repeat (3) @(posedge core_clk);
        rd(REG_STATUS, 32'h600, 32'h200);
        jitter_depth <= 8'h80;
        repeat (3) @(posedge core_clk);
        rd(REG_STATUS, 32'h200, 32'h0);
        wr(REG_CTRL, 32'h80);
        repeat (2) @(negedge core_clk);
        chk(code_ami, 1'h1);
        wr(REG_CTRL, 32'h40);
        det_framing <= FRAME_SLC;
        zero_run <= 1'h1;
        @(posedge core_clk) zero_run <= 1'h0;
        repeat (2) @(negedge core_clk);
        chk({frame_sel, code_ami}, {FRAME_SLC, 1'h1});
        @(posedge core_clk) b8zs_word <= 1'h1;
        @(posedge core_clk) b8zs_word <= 1'h0;
        repeat (2) @(negedge core_clk);
        chk(code_ami, 1'h0);
        rd(REG_STATUS, 32'h100, 32'h100);
        repeat (40) @(posedge core_clk);
        rd(REG_STATUS, 32'h100, 32'h0);
        wr(REG_CHAN_SEL, 32'h7);
        rd(REG_CHAN_SEL, 32'hffffffff, 32'h7);
        wr(REG_FRAC_MASK, 32'hffffff);
        wr(REG_CTRL, 32'h104);
        repeat (2) @(negedge core_clk);
        chk(bert_chan_en, 1'h1);
        wr(REG_FRAC_MASK, 32'h0);
        rd(REG_FRAC_MASK, 32'hffffffff, 32'h0);
        @(negedge core_clk) chk(bert_chan_en, 1'h0);
        wr(REG_HDSL_CMD, 32'h1a5);
        @(negedge core_clk) chk({hdsl_send, hdsl_code}, {1'h1, ARM_CODE});
        @(posedge core_clk) hdsl_done <= 1'h1;
        @(posedge core_clk) hdsl_done <= 1'h0;
        @(posedge core_clk);
        @(negedge core_clk) chk({hdsl_send, hdsl_code}, 9'h1a5);
        @(posedge core_clk) hdsl_done <= 1'h1;
        @(posedge core_clk) hdsl_done <= 1'h0;
        wr(REG_HDSL_CMD, 32'h22);
        @(negedge core_clk) chk({hdsl_send, hdsl_code}, 9'h122);
        finish_test;
    end
endmodule
